// [logic/dpx_cfg.svh]
// Constants for the paged data address extender
`ifndef DPX_CFG_SVH
`define DPX_CFG_SVH

`define DPX_PAGE_W        10
`define DPX_EA_W          16
`define DPX_EA_TOP        15
`define DPX_PAGE_RST      10'h001
`define DPX_PAGE_ZERO     10'h000
`define DPX_PAGE_ONE      10'h001
`define DPX_EDS_FIRST     10'h001
`define DPX_EDS_LAST      10'h1FF
`define DPX_PSV_FIRST     10'h200
`define DPX_PSV_LSW_LAST  10'h2FF
`define DPX_PSV_MSB_FIRST 10'h300
`define DPX_PSV_LAST      10'h3FF

`endif

// [logic/dpx_pkg.sv]
// Types for the paged data address extender
`default_nettype none

package dpx_pkg;

    // How the core formed the effective address
    typedef enum logic [2:0] {
        DPX_MODE_DIRECT = 3'h0,
        DPX_MODE_PRE    = 3'h1,
        DPX_MODE_POST   = 3'h3,
        DPX_MODE_OFFSET = 3'h2,
        DPX_MODE_MODULO = 3'h6,
        DPX_MODE_BITREV = 3'h7
    } dpx_mode_t;

    // Space that an access lands in
    typedef enum logic [1:0] {
        DPX_SPACE_BASE = 2'h0,
        DPX_SPACE_EDS  = 2'h1,
        DPX_SPACE_PSV  = 2'h3
    } dpx_space_t;

endpackage

`default_nettype wire

// [logic/dpx_page_reg.sv]
// One page register with load and crossing update
`include "dpx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dpx_page_reg
    import dpx_pkg::*;
#(
    parameter int PAGE_W = `DPX_PAGE_W
)
(
    // Clock and control
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // Direct load from the core
    input  wire logic              load,
    input  wire logic [PAGE_W-1:0] loadVal,
    // Update from a page crossing
    input  wire logic              upd,
    input  wire logic [PAGE_W-1:0] updVal,
    // Current page
    output logic      [PAGE_W-1:0] page
);

    logic [PAGE_W-1:0] page_ff;
    logic [PAGE_W-1:0] nxt_page;

    // A direct load beats a crossing in the same cycle
    assign nxt_page = load ? loadVal : (upd ? updVal : page_ff);
    assign page     = page_ff;

    always_ff @(posedge clk)
    begin
        if (srst)
            page_ff <= PAGE_W'(`DPX_PAGE_RST);
        else if (ce)
            page_ff <= nxt_page;
    end

endmodule

`default_nettype wire

// [logic/dpx_page_step.sv]
// Page and top address bit outcome of a page crossing
`include "dpx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dpx_page_step
    import dpx_pkg::*;
#(
    parameter int PAGE_W = `DPX_PAGE_W
)
(
    // Crossing description
    input  wire logic              stepMode,
    input  wire logic              isWrite,
    input  wire logic              isOvf,
    input  wire logic              isUnf,
    input  wire logic [PAGE_W-1:0] page,
    // Outcome
    output logic      [PAGE_W-1:0] stepPage,
    output logic                   stepTop
);

    logic ovfKeep;
    logic unfKeep;
    logic keepPage;

    assign ovfKeep  = isOvf && ((page == PAGE_W'(`DPX_EDS_LAST)) ||
                      (!isWrite && page == PAGE_W'(`DPX_PSV_LAST)));
    assign unfKeep  = isUnf && ((page == PAGE_W'(`DPX_EDS_FIRST)) ||
                      (!isWrite && page == PAGE_W'(`DPX_PSV_FIRST)));
    assign keepPage = !stepMode || ovfKeep || unfKeep;

    // 0x2FF and 0x300 cross naturally by plus or minus one
    assign stepPage = keepPage ? page :
                      (isOvf ? page + PAGE_W'(1) : page - PAGE_W'(1));
    // Boundary exceptions only apply to pre and post modify; wrap modes always set the top bit
    assign stepTop  = !(stepMode && (ovfKeep || unfKeep));

endmodule

`default_nettype wire

// [logic/dpx_page_ext.sv]
// Paged data space address extension between address generation and data bus
`include "dpx_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dpx_page_ext
    import dpx_pkg::*;
#(
    parameter int PAGE_W = `DPX_PAGE_W,
    parameter int EA_W   = `DPX_EA_W
)
(
    // Clock and control
    input  wire logic              clk,
    input  wire logic              srst,
    input  wire logic              ce,
    // Page register loads from the core
    input  wire logic              readPageLoad,
    input  wire logic              writePageLoad,
    input  wire logic [PAGE_W-1:0] pageLoadData,
    // Address request from address generation
    input  wire logic              reqValid,
    input  wire logic              reqWrite,
    input  wire dpx_mode_t         reqMode,
    input  wire logic              reqUp,
    input  wire logic              reqUseNew,
    input  wire logic [EA_W-1:0]   reqOldEa,
    input  wire logic [EA_W-1:0]   reqNewEa,
    // Result towards core writeback and data bus
    output logic                   eaValid,
    output logic      [EA_W-1:0]   eaOut,
    output logic      [EA_W-1:0]   accAddr,
    output logic      [PAGE_W-1:0] accPage,
    output dpx_space_t             accSpace,
    output logic                   accWrite,
    output logic                   addrErrTrap,
    // Page registers
    output logic      [PAGE_W-1:0] dataReadPage,
    output logic      [PAGE_W-1:0] dataWritePage
);

    localparam int TOP = `DPX_EA_TOP;

    logic [PAGE_W-1:0]      pageQ [2];
    logic [1:0]             pageLoad;
    logic [1:0]             pageUpd;

    logic              eaValid_ff;
    logic [EA_W-1:0]   eaOut_ff;
    logic [EA_W-1:0]   accAddr_ff;
    logic [PAGE_W-1:0] accPage_ff;
    dpx_space_t        accSpace_ff;
    logic              accWrite_ff;
    logic              trap_ff;

    // Request decode
    wire [PAGE_W-1:0] activePage = reqWrite ? pageQ[1] : pageQ[0];
    wire              fromPaged  = reqOldEa[TOP] && (activePage != PAGE_W'(`DPX_PAGE_ZERO));
    wire              stepMode   = (reqMode == DPX_MODE_PRE) || (reqMode == DPX_MODE_POST);
    wire              wrapMode   = (reqMode == DPX_MODE_OFFSET) ||
                                   (reqMode == DPX_MODE_MODULO) ||
                                   (reqMode == DPX_MODE_BITREV);
    wire              isCross    = reqValid && fromPaged && !reqNewEa[TOP] &&
                                   (stepMode || wrapMode);
    wire              isOvf      = isCross && reqUp;
    wire              isUnf      = isCross && !reqUp;

    logic [PAGE_W-1:0] stepPage;
    logic              stepTop;

    dpx_page_step #(
        .PAGE_W   (PAGE_W)
    ) u_step (
        .stepMode (stepMode),
        .isWrite  (reqWrite),
        .isOvf    (isOvf),
        .isUnf    (isUnf),
        .page     (activePage),
        .stepPage (stepPage),
        .stepTop  (stepTop)
    );

    // Clear the top bit, then set it again as the crossing dictates
    wire [EA_W-1:0] eaCleared = {1'b0, reqNewEa[TOP-1:0]};
    wire [EA_W-1:0] eaAdj     = isCross ? (eaCleared | {stepTop, {TOP{1'b0}}})
                                        : reqNewEa;
    wire [EA_W-1:0] accEa     = reqUseNew ? eaAdj : reqOldEa;

    // Access target: address and page that the data bus sees
    wire              pageMoves = isCross && stepMode && (stepPage != activePage);
    wire [PAGE_W-1:0] accPg     = (reqUseNew && pageMoves) ? stepPage : activePage;
    wire              isPsvPage = accPg >= PAGE_W'(`DPX_PSV_FIRST);
    wire dpx_space_t  spaceNow  = !accEa[TOP] ? DPX_SPACE_BASE :
                                  (isPsvPage ? DPX_SPACE_PSV : DPX_SPACE_EDS);
    wire              zeroTrap  = accEa[TOP] && (accPg == PAGE_W'(`DPX_PAGE_ZERO));
    wire              psWrTrap  = reqWrite && accEa[TOP] && isPsvPage;
    wire              trapNow   = reqValid && (zeroTrap || psWrTrap);

    // Page register updates; a trapping request leaves the pages alone
    wire crossUpd = reqValid && pageMoves && !trapNow;
    assign pageLoad = {writePageLoad, readPageLoad};
    assign pageUpd  = {crossUpd && reqWrite, crossUpd && !reqWrite};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_page
            dpx_page_reg #(
                .PAGE_W  (PAGE_W)
            ) u_page (
                .clk     (clk),
                .srst    (srst),
                .ce      (ce),
                .load    (pageLoad[gi]),
                .loadVal (pageLoadData),
                .upd     (pageUpd[gi]),
                .updVal  (stepPage),
                .page    (pageQ[gi])
            );
        end
    endgenerate

    // Writeback and access registers share the page update edge
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            eaValid_ff  <= 1'b0;
            eaOut_ff    <= '0;
            accAddr_ff  <= '0;
            accPage_ff  <= '0;
            accSpace_ff <= DPX_SPACE_BASE;
            accWrite_ff <= 1'b0;
            trap_ff     <= 1'b0;
        end
        else if (ce)
        begin
            eaValid_ff  <= reqValid;
            eaOut_ff    <= reqValid ? eaAdj : eaOut_ff;
            accAddr_ff  <= reqValid ? accEa : accAddr_ff;
            accPage_ff  <= reqValid ? accPg : accPage_ff;
            accSpace_ff <= reqValid ? spaceNow : accSpace_ff;
            accWrite_ff <= reqValid ? reqWrite : accWrite_ff;
            trap_ff     <= trapNow;
        end
    end

    assign eaValid       = eaValid_ff;
    assign eaOut         = eaOut_ff;
    assign accAddr       = accAddr_ff;
    assign accPage       = accPage_ff;
    assign accSpace      = accSpace_ff;
    assign accWrite      = accWrite_ff;
    assign addrErrTrap   = trap_ff;
    assign dataReadPage  = pageQ[0];
    assign dataWritePage = pageQ[1];

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    wire quiet = !readPageLoad && !writePageLoad && !trapNow;
    wire rdGo  = ce && reqValid && !reqWrite && quiet;
    wire wrGo  = ce && reqValid && reqWrite && quiet;

    sep_pages_a: assert property (
        rdGo |=> $stable(dataWritePage))
        else $error("read request moved the write page");

    side_page_a: assert property (
        ce && reqValid && !reqUseNew |=> accPage == $past(activePage))
        else $error("access page not taken from its own page register");

    no_offset_step_a: assert property (
        ce && reqValid && quiet && wrapMode |=>
            $stable(dataReadPage) && $stable(dataWritePage))
        else $error("wrap mode changed a page register");

    top_clear_a: assert property (
        ce && isCross && !stepTop |=> !eaOut[TOP] && eaValid)
        else $error("top address bit not cleared at a boundary");

    ovf_inc_a: assert property (
        rdGo && isOvf && stepMode && stepTop |=>
            dataReadPage == $past(dataReadPage) + PAGE_W'(1) && eaOut[TOP])
        else $error("overflow did not advance the read page");

    unf_dec_a: assert property (
        wrGo && isUnf && stepMode && stepTop |=>
            dataWritePage == $past(dataWritePage) - PAGE_W'(1) && eaOut[TOP])
        else $error("underflow did not step back the write page");

    wrap_keep_a: assert property (
        rdGo && isCross && wrapMode |=> eaOut[TOP] && $stable(dataReadPage))
        else $error("wrap mode crossing mishandled");

    ovf_edge_a: assert property (
        rdGo && isOvf && stepMode && activePage == PAGE_W'(`DPX_PSV_LSW_LAST) |=>
            dataReadPage == PAGE_W'(`DPX_PSV_MSB_FIRST) && eaOut[TOP])
        else $error("read overflow at 0x2FF did not reach 0x300");

    unf_edge_a: assert property (
        rdGo && isUnf && stepMode && activePage == PAGE_W'(`DPX_PSV_MSB_FIRST) |=>
            dataReadPage == PAGE_W'(`DPX_PSV_LSW_LAST) && eaOut[TOP])
        else $error("read underflow at 0x300 did not reach 0x2FF");

    base_target_a: assert property (
        eaValid && !accAddr[TOP] |-> accSpace == DPX_SPACE_BASE)
        else $error("unpaged address not sent to base space");

    zero_trap_a: assert property (
        ce && reqValid && accEa[TOP] && accPg == PAGE_W'(`DPX_PAGE_ZERO) |=> addrErrTrap)
        else $error("page zero access did not trap");

    ps_write_trap_a: assert property (
        ce && reqValid && reqWrite && accEa[TOP] && isPsvPage |=>
            addrErrTrap && $stable(dataWritePage))
        else $error("program space write did not trap");

    same_edge_a: assert property (
        ce && crossUpd && quiet |=> eaValid &&
            ($past(reqWrite) ? $changed(dataWritePage) : $changed(dataReadPage)))
        else $error("page update and writeback not on the same edge");

    wire ovfAtEnd = (activePage == PAGE_W'(`DPX_EDS_LAST)) ||
                    (!reqWrite && activePage == PAGE_W'(`DPX_PSV_LAST));
    wire unfAtEnd = (activePage == PAGE_W'(`DPX_EDS_FIRST)) ||
                    (!reqWrite && activePage == PAGE_W'(`DPX_PSV_FIRST));

    direct_no_cross_a: assert property (
        ce && reqValid && quiet && reqMode == DPX_MODE_DIRECT |=>
            eaOut == $past(reqNewEa) && $stable(dataReadPage) && $stable(dataWritePage))
        else $error("direct access changed its address or a page");

    wr_ovf_inc_a: assert property (
        wrGo && isOvf && stepMode && stepTop |=>
            dataWritePage == $past(dataWritePage) + PAGE_W'(1) && eaOut[TOP])
        else $error("overflow did not advance the write page");

    rd_unf_dec_a: assert property (
        rdGo && isUnf && stepMode && stepTop |=>
            dataReadPage == $past(dataReadPage) - PAGE_W'(1) && eaOut[TOP])
        else $error("underflow did not step back the read page");

    ovf_keep_a: assert property (
        ce && reqValid && quiet && isOvf && stepMode && ovfAtEnd |=>
            !eaOut[TOP] && $stable(dataReadPage) && $stable(dataWritePage))
        else $error("overflow at a last page did not hold the page");

    unf_keep_a: assert property (
        ce && reqValid && quiet && isUnf && stepMode && unfAtEnd |=>
            !eaOut[TOP] && $stable(dataReadPage) && $stable(dataWritePage))
        else $error("underflow at a first page did not hold the page");

    trap_keep_a: assert property (
        ce && trapNow && !readPageLoad && !writePageLoad |=>
            $stable(dataReadPage) && $stable(dataWritePage))
        else $error("trapping access moved a page register");

    trap_pulse_a: assert property (
        ce && !trapNow |=> !addrErrTrap)
        else $error("address error trap without a trapping access");

    load_rd_a: assert property (
        ce && readPageLoad |=> dataReadPage == $past(pageLoadData))
        else $error("read page load lost");

    load_wr_a: assert property (
        ce && writePageLoad |=> dataWritePage == $past(pageLoadData))
        else $error("write page load lost");

    acc_dir_a: assert property (
        ce && reqValid |=> accWrite == $past(reqWrite))
        else $error("access direction not kept");

    psv_space_a: assert property (
        eaValid && accAddr[TOP] && accPage >= PAGE_W'(`DPX_PSV_FIRST) |->
            accSpace == DPX_SPACE_PSV)
        else $error("program window page not sent to program space");

    eds_space_a: assert property (
        eaValid && accAddr[TOP] && accPage < PAGE_W'(`DPX_PSV_FIRST) |->
            accSpace == DPX_SPACE_EDS)
        else $error("data page not sent to extended data space");

    ce_freeze_a: assert property (
        !ce |=> $stable(eaValid) && $stable(eaOut) && $stable(addrErrTrap) &&
            $stable(dataReadPage) && $stable(dataWritePage))
        else $error("state moved while the clock enable was low");

    psv_to_eds_c: cover property (
        ce && reqValid && !reqWrite && isPsvPage ##1 ce && reqValid && reqWrite && !isPsvPage);
    ovf_step_c: cover property (rdGo && isOvf && stepMode && stepTop);
    unf_keep_c: cover property (rdGo && isUnf && stepMode && !stepTop);
    trap_c: cover property (addrErrTrap);
    wrap_edge_c: cover property (
        rdGo && isOvf && wrapMode && activePage == PAGE_W'(`DPX_EDS_LAST));

endmodule

`default_nettype wire

// [verif/dpx_core_model.sv]
// Address generation model of the core that feeds requests and page loads
`timescale 1ns/1ns
`default_nettype none

module dpx_core_model
    import dpx_pkg::*;
(
    // Clock
    input  wire logic        clk,
    // Page loads
    output logic             readPageLoad,
    output logic             writePageLoad,
    output logic [9:0]       pageLoadData,
    // Address request
    output logic             reqValid,
    output logic             reqWrite,
    output dpx_mode_t        reqMode,
    output logic             reqUp,
    output logic             reqUseNew,
    output logic [15:0]      reqOldEa,
    output logic [15:0]      reqNewEa
);
    logic useNewSel = 1'b1;

    initial
    begin
        readPageLoad  = 1'b0;
        writePageLoad = 1'b0;
        pageLoadData  = 10'h000;
        reqValid      = 1'b0;
        reqWrite      = 1'b0;
        reqMode       = DPX_MODE_DIRECT;
        reqUp         = 1'b0;
        reqUseNew     = 1'b1;
        reqOldEa      = 16'h0000;
        reqNewEa      = 16'h0000;
    end

    // Load one page register for one cycle
    task automatic loadPage(input logic wr, input logic [9:0] val);
        @(negedge clk);
        readPageLoad  = !wr;
        writePageLoad = wr;
        pageLoadData  = val;
        @(negedge clk);
        readPageLoad  = 1'b0;
        writePageLoad = 1'b0;
        pageLoadData  = ~val;
    endtask

    // One request; offsets stay small so a crossing is a single page step
    task automatic issue(input logic wr, input dpx_mode_t mode, input logic [15:0] oldEa,
                         input int delta);
        @(negedge clk);
        reqValid = 1'b1;
        reqWrite = wr;
        reqMode  = mode;
        reqUp    = delta > 0;
        reqOldEa = oldEa;
        reqNewEa = oldEa + 16'(delta);
        reqUseNew = useNewSel;
        @(negedge clk);
        reqValid = 1'b0;
        reqOldEa = ~reqOldEa;
        reqNewEa = ~reqNewEa;
    endtask

    // Choose whether later requests access the modified or the unmodified address
    task automatic setUseNew(input logic v);
        useNewSel = v;
    endtask
endmodule

`default_nettype wire

// [verif/tb_dpx_page_ext.sv]
// Self-checking bench for the paged data address extender
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, exp, got) \
    begin \
        checkCount++; \
        if ((got) !== (exp)) \
        begin \
            $display("MISMATCH %s expected %h seen %h", nm, exp, got); \
            errors++; \
        end \
    end

module tb_dpx_page_ext
    import dpx_pkg::*;
;
    localparam logic [15:0] HI = 16'hFFFE;
    localparam logic [15:0] LO = 16'h8000;
    localparam logic        RD = 1'b0;
    localparam logic        WR = 1'b1;
    localparam dpx_space_t  SPB = DPX_SPACE_BASE;
    localparam dpx_space_t  SPE = DPX_SPACE_EDS;
    localparam dpx_space_t  SPP = DPX_SPACE_PSV;

    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        ce = 1'b1;
    logic        readPageLoad;
    logic        writePageLoad;
    logic [9:0]  pageLoadData;
    logic        reqValid;
    logic        reqWrite;
    dpx_mode_t   reqMode;
    logic        reqUp;
    logic        reqUseNew;
    logic [15:0] reqOldEa;
    logic [15:0] reqNewEa;
    logic        eaValid;
    logic [15:0] eaOut;
    logic [15:0] accAddr;
    logic [9:0]  accPage;
    dpx_space_t  accSpace;
    logic        accWrite;
    logic        addrErrTrap;
    logic [9:0]  dataReadPage;
    logic [9:0]  dataWritePage;
    int          errors = 0;
    int          checkCount = 0;
    int          cycles = 0;

    always #5 clk = ~clk;

    dpx_core_model i_dpx_core_model (.clk(clk), .readPageLoad(readPageLoad),
        .writePageLoad(writePageLoad), .pageLoadData(pageLoadData), .reqValid(reqValid),
        .reqWrite(reqWrite), .reqMode(reqMode), .reqUp(reqUp), .reqUseNew(reqUseNew),
        .reqOldEa(reqOldEa), .reqNewEa(reqNewEa));

    dpx_page_ext i_dpx_page_ext (.clk(clk), .srst(srst), .ce(ce),
        .readPageLoad(readPageLoad), .writePageLoad(writePageLoad),
        .pageLoadData(pageLoadData), .reqValid(reqValid), .reqWrite(reqWrite),
        .reqMode(reqMode), .reqUp(reqUp), .reqUseNew(reqUseNew), .reqOldEa(reqOldEa),
        .reqNewEa(reqNewEa), .eaValid(eaValid), .eaOut(eaOut), .accAddr(accAddr),
        .accPage(accPage), .accSpace(accSpace), .accWrite(accWrite),
        .addrErrTrap(addrErrTrap), .dataReadPage(dataReadPage),
        .dataWritePage(dataWritePage));

    task automatic stop_test();
        $display("Checks %0d, errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Load the active page, issue one request, judge the registered answer
    task automatic xfer(input logic wr, input logic [9:0] pg, input dpx_mode_t mode,
                        input logic [15:0] oldEa, input int delta, input logic [15:0] expEa,
                        input logic [9:0] expPg, input dpx_space_t expSp, input logic expTrap);
        i_dpx_core_model.loadPage(wr, pg);
        i_dpx_core_model.issue(wr, mode, oldEa, delta);
        `CHK("eaValid", 1'b1, eaValid)
        `CHK("eaOut", expEa, eaOut)
        `CHK("pageReg", expPg, (wr ? dataWritePage : dataReadPage))
        `CHK("accAddr", expEa, accAddr)
        `CHK("accPage", expPg, accPage)
        `CHK("accSpace", expSp, accSpace)
        `CHK("accWrite", wr, accWrite)
        `CHK("trap", expTrap, addrErrTrap)
    endtask

    task automatic t_reset();
        `CHK("readPage", 10'h001, dataReadPage)
        `CHK("writePage", 10'h001, dataWritePage)
        `CHK("eaValid", 1'b0, eaValid)
        `CHK("trap", 1'b0, addrErrTrap)
        `CHK("eaOut", 16'h0000, eaOut)
        `CHK("accAddr", 16'h0000, accAddr)
        `CHK("accPage", 10'h000, accPage)
        `CHK("accSpace", SPB, accSpace)
        `CHK("accWrite", 1'b0, accWrite)
    endtask

    // Clock enable low: a request is ignored and all state holds
    task automatic t_hold();
        i_dpx_core_model.loadPage(RD, 10'h100);
        ce = 1'b0;
        i_dpx_core_model.issue(RD, DPX_MODE_PRE, HI, 2);
        `CHK("eaValid", 1'b0, eaValid)
        `CHK("readPage", 10'h100, dataReadPage)
        `CHK("eaOut", LO, eaOut)
        `CHK("trap", 1'b0, addrErrTrap)
        ce = 1'b1;
    endtask

    // Post modify: access uses the old address and page, writeback the new ones
    task automatic t_use_old();
        i_dpx_core_model.setUseNew(1'b0);
        i_dpx_core_model.loadPage(RD, 10'h100);
        i_dpx_core_model.issue(RD, DPX_MODE_POST, HI, 2);
        i_dpx_core_model.setUseNew(1'b1);
        `CHK("eaOut", LO, eaOut)
        `CHK("readPage", 10'h101, dataReadPage)
        `CHK("accAddr", HI, accAddr)
        `CHK("accPage", 10'h100, accPage)
        `CHK("accSpace", SPE, accSpace)
    endtask

    // Reset in mid run returns every output to its reset value
    task automatic t_mid_reset();
        i_dpx_core_model.loadPage(WR, 10'h155);
        srst = 1'b1;
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_reset();
    endtask

    task automatic t_normal();
        xfer(RD, 10'h100, DPX_MODE_PRE, HI, 2, LO, 10'h101, SPE, 1'b0);
        xfer(RD, 10'h100, DPX_MODE_POST, LO, -2, HI, 10'h0FF, SPE, 1'b0);
        xfer(WR, 10'h0FF, DPX_MODE_POST, HI, 2, LO, 10'h100, SPE, 1'b0);
    endtask

    task automatic t_wrap();
        dpx_mode_t m[3];
        m = '{DPX_MODE_OFFSET, DPX_MODE_MODULO, DPX_MODE_BITREV};
        foreach (m[i])
        begin
            xfer(RD, 10'h100, m[i], HI, 2, LO, 10'h100, SPE, 1'b0);
            xfer(RD, 10'h100, m[i], LO, -2, HI, 10'h100, SPE, 1'b0);
        end
        xfer(RD, 10'h1FF, DPX_MODE_MODULO, HI, 2, LO, 10'h1FF, SPE, 1'b0);
    endtask

    task automatic t_bounds();
        xfer(RD, 10'h1FF, DPX_MODE_PRE, HI, 2, 16'h0000, 10'h1FF, SPB, 1'b0);
        xfer(RD, 10'h2FF, DPX_MODE_POST, HI, 2, LO, 10'h300, SPP, 1'b0);
        xfer(RD, 10'h3FF, DPX_MODE_PRE, HI, 2, 16'h0000, 10'h3FF, SPB, 1'b0);
        xfer(WR, 10'h1FF, DPX_MODE_POST, HI, 2, 16'h0000, 10'h1FF, SPB, 1'b0);
        xfer(RD, 10'h001, DPX_MODE_PRE, LO, -2, 16'h7FFE, 10'h001, SPB, 1'b0);
        xfer(RD, 10'h200, DPX_MODE_POST, LO, -2, 16'h7FFE, 10'h200, SPB, 1'b0);
        xfer(RD, 10'h300, DPX_MODE_PRE, LO, -2, HI, 10'h2FF, SPP, 1'b0);
    endtask

    task automatic t_split();
        xfer(RD, 10'h200, DPX_MODE_DIRECT, 16'h9000, 0, 16'h9000, 10'h200, SPP, 1'b0);
        xfer(WR, 10'h005, DPX_MODE_PRE, HI, 2, LO, 10'h006, SPE, 1'b0);
        `CHK("readPage", 10'h200, dataReadPage)
    endtask

    task automatic t_traps();
        xfer(RD, 10'h000, DPX_MODE_DIRECT, 16'h9000, 0, 16'h9000, 10'h000, SPE, 1'b1);
        xfer(WR, 10'h200, DPX_MODE_DIRECT, 16'h9000, 0, 16'h9000, 10'h200, SPP, 1'b1);
    endtask

    task automatic t_no_cross();
        xfer(RD, 10'h100, DPX_MODE_DIRECT, HI, 2, 16'h0000, 10'h100, SPB, 1'b0);
        xfer(RD, 10'h100, DPX_MODE_PRE, 16'h7FFE, 2, LO, 10'h100, SPE, 1'b0);
    endtask

    // Cut a hang short
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        t_reset();
        t_normal();
        t_hold();
        t_use_old();
        t_wrap();
        t_bounds();
        t_split();
        t_traps();
        t_mid_reset();
        t_no_cross();
        stop_test();
    end
endmodule

`default_nettype wire
